//--- twc_pkg.sv
// constants and types shared by the two-wire control slave
package twc_pkg;
  localparam int CLK_PERIOD_NS = 5;
  localparam int SPIKE_NS = 8;
  // a level must stand longer than the widest spike before it is believed
  localparam int SPIKE_CYC = (SPIKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
  localparam int BYTE_BITS = 8;
  localparam logic [6:0] ADDR_SEL0 = 7'h1A;
  localparam logic [6:0] ADDR_SEL1 = 7'h1B;
  localparam logic [6:0] SOFT_RST_IDX = 7'h00;
  localparam logic [15:0] REG_DEFAULT = 16'h0000;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_ACK = 3'b010,
    ST_RX = 3'b011,
    ST_TX = 3'b100,
    ST_TXACK = 3'b101,
    ST_IGNORE = 3'b110
  } twc_state_t;

  typedef struct packed {
    logic [6:0] idx;
    logic [15:0] data;
  } twc_wr_t;
endpackage

//--- twc_slave.sv
// two-wire control slave with register store and audio-domain write handoff
`timescale 1ns/100ps
`default_nettype none
module twc_slave #(
  parameter int NUM_REGS = 128,
  parameter logic [15:0] DEV_ID = 16'hA5C3 // arbitrary value
) (
  // control clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // audio clock domain
  input wire logic aud_clk_i,
  input wire logic aud_rstn_i,
  // strap pins and configuration
  input wire logic interface_select_pin_i,
  input wire logic addr_sel_i,
  input wire logic auto_inc_i,
  // two-wire bus; no clock output exists at all
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oen_o,
  // register writes in the audio domain
  output logic aud_wr_o,
  output twc_pkg::twc_wr_t aud_wr_data_o,
  output logic aud_soft_rst_o
);
  logic [3:0] s1_r;
  logic [3:0] s2_r;
  logic [1:0] flt_r;
  logic [1:0] prev_r;
  logic [1:0][1:0] fcnt_r;
  twc_pkg::twc_state_t state_r;
  logic [3:0] bcnt_r;
  logic [7:0] sh_r;
  logic [1:0] byte_cnt_r;
  logic [6:0] idx_r;
  logic [7:0] hi_r;
  logic lo_ok_r;
  logic go_tx_r;
  logic [15:0] tx_sh_r;
  logic half_r;
  logic mack_r;
  logic sda_oen_r;
  logic [15:0] regs_r [NUM_REGS];
  twc_pkg::twc_wr_t wr_hold_r;
  logic wr_tgl_r;
  logic at1_r, at2_r, at3_r;
  logic aud_wr_r;
  logic aud_soft_rst_r;
  twc_pkg::twc_wr_t aud_data_r;

  logic mode_r, asel_r, scl_f, sda_f;
  logic scl_rise, scl_fall, start_w, stop_w, wr_en;
  logic [6:0] own_addr;
  logic [15:0] rd_cur_w;
  logic [15:0] rd_inc_w;

  function automatic logic [15:0] rd_word(input logic [6:0] idx);
    rd_word = (idx == twc_pkg::SOFT_RST_IDX) ? DEV_ID : regs_r[idx];
  endfunction

  // current word, and the next one for auto-increment reads
  assign rd_cur_w = rd_word(idx_r);
  assign rd_inc_w = rd_word(idx_r + 7'h01);

  // pins pass two flops; bit 3 mode, 2 address select, 1 clock, 0 data
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      s1_r <= 4'hF;
      s2_r <= 4'hF;
    end else begin
      s1_r <= {interface_select_pin_i, addr_sel_i, scl_i, sda_i};
      s2_r <= s1_r;
    end
  end

  assign mode_r = s2_r[3];
  assign asel_r = s2_r[2];
  assign own_addr = asel_r ? twc_pkg::ADDR_SEL1 : twc_pkg::ADDR_SEL0;

  // spike filter: costs three cycles of latency, far below setup margins
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      flt_r <= 2'h3;
      prev_r <= 2'h3;
      fcnt_r <= '0;
    end else begin
      prev_r <= flt_r;
      for (int i = 0; i < 2; i++) begin
        if (s2_r[i] == flt_r[i]) begin
          fcnt_r[i] <= 2'h0;
        end else if (fcnt_r[i] == 2'(twc_pkg::SPIKE_CYC - 1)) begin
          flt_r[i] <= s2_r[i];
          fcnt_r[i] <= 2'h0;
        end else begin
          fcnt_r[i] <= fcnt_r[i] + 2'h1;
        end
      end
    end
  end

  assign scl_f = flt_r[1];
  assign sda_f = flt_r[0];
  assign scl_rise = scl_f & ~prev_r[1];
  assign scl_fall = ~scl_f & prev_r[1];
  assign start_w = scl_f & prev_r[1] & prev_r[0] & ~sda_f;
  assign stop_w = scl_f & prev_r[1] & ~prev_r[0] & sda_f;
  // a mode change in the last ack aborts the transfer, so no commit then
  assign wr_en = (state_r == twc_pkg::ST_ACK) && scl_fall && lo_ok_r && !mode_r;

  always_ff @(posedge clk_i) begin
    if (!rstn_i || mode_r) begin
      state_r <= twc_pkg::ST_IDLE;
      bcnt_r <= 4'h0;
      sh_r <= 8'h00;
      byte_cnt_r <= 2'h0;
      idx_r <= 7'h00;
      hi_r <= 8'h00;
      lo_ok_r <= 1'b0;
      go_tx_r <= 1'b0;
      tx_sh_r <= 16'h0000;
      half_r <= 1'b0;
      mack_r <= 1'b0;
      sda_oen_r <= 1'b1;
    end else if (start_w) begin
      // a start anywhere drops partial data; the index survives for readback
      state_r <= twc_pkg::ST_ADDR;
      bcnt_r <= 4'h0;
      byte_cnt_r <= 2'h0;
      lo_ok_r <= 1'b0;
      sda_oen_r <= 1'b1;
    end else if (stop_w) begin
      state_r <= twc_pkg::ST_IDLE;
      lo_ok_r <= 1'b0;
      sda_oen_r <= 1'b1;
    end else begin
      unique case (state_r)
        twc_pkg::ST_IDLE, twc_pkg::ST_IGNORE: begin
        end
        twc_pkg::ST_ADDR, twc_pkg::ST_RX: begin
          if (scl_rise) begin
            sh_r <= {sh_r[6:0], sda_f};
            bcnt_r <= bcnt_r + 4'h1;
          end else if (scl_fall && bcnt_r == 4'(twc_pkg::BYTE_BITS)) begin
            bcnt_r <= 4'h0;
            if (state_r == twc_pkg::ST_ADDR) begin
              if (sh_r[7:1] == own_addr) begin
                sda_oen_r <= 1'b0;
                go_tx_r <= sh_r[0];
                lo_ok_r <= 1'b0;
                state_r <= twc_pkg::ST_ACK;
              end else begin
                state_r <= twc_pkg::ST_IGNORE;
              end
            end else if (!auto_inc_i && byte_cnt_r == 2'h3) begin
              state_r <= twc_pkg::ST_IGNORE;
            end else begin
              sda_oen_r <= 1'b0;
              go_tx_r <= 1'b0;
              state_r <= twc_pkg::ST_ACK;
              lo_ok_r <= (byte_cnt_r == 2'h2);
              byte_cnt_r <= byte_cnt_r + 2'h1;
              if (byte_cnt_r == 2'h0) begin
                idx_r <= sh_r[6:0];
              end
              if (byte_cnt_r == 2'h1) begin
                hi_r <= sh_r;
              end
            end
          end
        end
        twc_pkg::ST_ACK: begin
          if (scl_fall) begin
            lo_ok_r <= 1'b0;
            if (lo_ok_r && auto_inc_i) begin
              idx_r <= idx_r + 7'h01;
              byte_cnt_r <= 2'h1;
            end
            if (go_tx_r) begin
              tx_sh_r <= rd_cur_w;
              sda_oen_r <= rd_cur_w[15];
              half_r <= 1'b0;
              bcnt_r <= 4'h0;
              state_r <= twc_pkg::ST_TX;
            end else begin
              sda_oen_r <= 1'b1;
              state_r <= twc_pkg::ST_RX;
            end
          end
        end
        twc_pkg::ST_TX: begin
          if (scl_fall) begin
            if (bcnt_r == 4'h7) begin
              sda_oen_r <= 1'b1;
              bcnt_r <= 4'h0;
              mack_r <= 1'b0;
              state_r <= twc_pkg::ST_TXACK;
            end else begin
              tx_sh_r <= {tx_sh_r[14:0], 1'b0};
              sda_oen_r <= tx_sh_r[14];
              bcnt_r <= bcnt_r + 4'h1;
            end
          end
        end
        twc_pkg::ST_TXACK: begin
          if (scl_rise) begin
            mack_r <= ~sda_f;
          end else if (scl_fall) begin
            if (!mack_r) begin
              state_r <= twc_pkg::ST_IGNORE;
            end else if (!half_r) begin
              half_r <= 1'b1;
              tx_sh_r <= {tx_sh_r[14:0], 1'b0};
              sda_oen_r <= tx_sh_r[14];
              state_r <= twc_pkg::ST_TX;
            end else if (auto_inc_i) begin
              idx_r <= idx_r + 7'h01;
              tx_sh_r <= rd_inc_w;
              sda_oen_r <= rd_inc_w[15];
              half_r <= 1'b0;
              state_r <= twc_pkg::ST_TX;
            end else begin
              state_r <= twc_pkg::ST_IGNORE;
            end
          end
        end
        default: begin
          state_r <= twc_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // register store
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        regs_r[i] <= twc_pkg::REG_DEFAULT;
      end
    end else if (wr_en) begin
      if (idx_r == twc_pkg::SOFT_RST_IDX) begin
        for (int i = 0; i < NUM_REGS; i++) begin
          regs_r[i] <= twc_pkg::REG_DEFAULT;
        end
      end else begin
        regs_r[idx_r] <= {hi_r, sh_r};
      end
    end
  end

  // held word plus toggle; a new write is at least nine bus clocks away
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      wr_hold_r <= '0;
      wr_tgl_r <= 1'b0;
    end else if (wr_en) begin
      wr_hold_r <= '{idx: idx_r, data: {hi_r, sh_r}};
      wr_tgl_r <= ~wr_tgl_r;
    end
  end

  always_ff @(posedge aud_clk_i) begin
    if (!aud_rstn_i) begin
      at1_r <= 1'b0;
      at2_r <= 1'b0;
      at3_r <= 1'b0;
      aud_wr_r <= 1'b0;
      aud_soft_rst_r <= 1'b0;
      aud_data_r <= '0;
    end else begin
      at1_r <= wr_tgl_r;
      at2_r <= at1_r;
      at3_r <= at2_r;
      aud_wr_r <= at2_r ^ at3_r;
      aud_soft_rst_r <= (at2_r ^ at3_r) && (wr_hold_r.idx == twc_pkg::SOFT_RST_IDX);
      if (at2_r ^ at3_r) begin
        aud_data_r <= wr_hold_r;
      end
    end
  end

  assign sda_o = 1'b0;
  assign sda_oen_o = sda_oen_r;
  assign aud_wr_o = aud_wr_r;
  assign aud_wr_data_o = aud_data_r;
  assign aud_soft_rst_o = aud_soft_rst_r;

  mode_gate_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    mode_r |=> sda_oen_o && state_r == twc_pkg::ST_IDLE) else $error("mode pin not gating");
  start_seen_a: assert property (@(posedge clk_i) disable iff (!rstn_i || mode_r)
    start_w |=> state_r == twc_pkg::ST_ADDR && bcnt_r == 4'h0) else $error("start missed");
  addr_shift_a: assert property (@(posedge clk_i) disable iff (!rstn_i || mode_r)
    state_r == twc_pkg::ST_ADDR && scl_rise && !start_w && !stop_w |=> sh_r[0] == $past(sda_f))
    else $error("address bit not shifted");
  addr_ack_a: assert property (@(posedge clk_i) disable iff (!rstn_i || mode_r)
    state_r == twc_pkg::ST_ADDR && scl_fall && bcnt_r == 4'h8 && sh_r[7:1] == own_addr
    |=> !sda_oen_o && state_r == twc_pkg::ST_ACK) else $error("own address not acked");
  addr_nack_a: assert property (@(posedge clk_i) disable iff (!rstn_i || mode_r)
    state_r == twc_pkg::ST_ADDR && scl_fall && bcnt_r == 4'h8 && sh_r[7:1] != own_addr
    |=> sda_oen_o && state_r == twc_pkg::ST_IGNORE) else $error("foreign address acked");
  addr_pin_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    {own_addr, 1'b0} == (asel_r ? 8'h36 : 8'h34)) else $error("bus address wrong");
  stop_idle_a: assert property (@(posedge clk_i) disable iff (!rstn_i || mode_r)
    stop_w && !start_w |=> state_r == twc_pkg::ST_IDLE && sda_oen_o) else $error("stop ignored");
  sda_release_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    state_r inside {twc_pkg::ST_IDLE, twc_pkg::ST_IGNORE, twc_pkg::ST_ADDR,
    twc_pkg::ST_RX, twc_pkg::ST_TXACK} |-> sda_oen_o) else $error("data driven out of turn");
  commit_time_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    wr_en |-> byte_cnt_r == 2'h3 && $past(state_r, 1) == twc_pkg::ST_ACK)
    else $error("write before second data byte");
  soft_reset_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    wr_en && idx_r == twc_pkg::SOFT_RST_IDX |=> regs_r[1] == twc_pkg::REG_DEFAULT)
    else $error("soft reset left a register set");
  tx_msb_a: assert property (@(posedge clk_i) disable iff (!rstn_i || mode_r)
    state_r == twc_pkg::ST_ACK && go_tx_r && scl_fall && !start_w && !stop_w
    |=> sda_oen_o == $past(rd_cur_w[15])) else $error("read msb wrong");
  aud_pulse_a: assert property (@(posedge aud_clk_i) disable iff (!aud_rstn_i)
    $rose(aud_wr_r) |=> !aud_wr_r) else $error("audio write pulse too long");

  write_cov: cover property (@(posedge clk_i) disable iff (!rstn_i) wr_en && idx_r != 7'h00);
  soft_cov: cover property (@(posedge clk_i) disable iff (!rstn_i) wr_en && idx_r == 7'h00);
  read_cov: cover property (@(posedge clk_i) disable iff (!rstn_i)
    state_r == twc_pkg::ST_TXACK && half_r && scl_fall);
  auto_cov: cover property (@(posedge clk_i) disable iff (!rstn_i)
    state_r == twc_pkg::ST_TXACK && half_r && mack_r && auto_inc_i && scl_fall);
endmodule
`default_nettype wire

//--- twc_host_model.sv
// bus controller model driving the two-wire lines for the bench
`timescale 1ns/100ps
`default_nettype none
module twc_host_model #(
  parameter int QTR_CYC = 10
) (
  // control clock
  input wire logic clk_i,
  // wired data line as all parties see it
  input wire logic sda_i,
  // open drain drives, 0 pulls low
  output var logic scl_o,
  output var logic sda_o
);
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  // quarter bit; phases stay well above the slave's filter delay
  task automatic qtr();
    repeat (QTR_CYC) @(posedge clk_i);
  endtask
  // entered with clock low this is a repeated start
  task automatic start();
    sda_o <= 1'b1;
    qtr();
    scl_o <= 1'b1;
    qtr();
    sda_o <= 1'b0;
    qtr();
    scl_o <= 1'b0;
    qtr();
  endtask
  task automatic stop();
    sda_o <= 1'b0;
    qtr();
    scl_o <= 1'b1;
    qtr();
    sda_o <= 1'b1;
    qtr();
  endtask
  task automatic bit_x(input logic b, output logic r);
    sda_o <= b;
    qtr();
    scl_o <= 1'b1;
    qtr();
    r = sda_i;
    qtr();
    scl_o <= 1'b0;
    qtr();
  endtask
  task automatic byte_x(input logic [7:0] d, input logic ack_b, output logic [7:0] r,
                        output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], r[i]);
    end
    bit_x(ack_b, ack);
  endtask
  // one-cycle clock pulse, narrower than the widest rejected spike
  task automatic spike();
    scl_o <= 1'b1;
    @(posedge clk_i);
    scl_o <= 1'b0;
    qtr();
  endtask
endmodule
`default_nettype wire

//--- tb_two_wire_control_slave.sv
// self-checking bench for the two-wire control slave
`timescale 1ns/100ps
`default_nettype none
module tb_two_wire_control_slave;
  localparam logic [15:0] ID_VAL = 16'h5A3C; // arbitrary value
  logic clk_i = 1'b0;
  logic aud_clk = 1'b0;
  logic rstn_i = 1'b0;
  logic aud_rstn = 1'b0;
  logic if_sel = 1'b0;
  logic addr_sel = 1'b0;
  logic auto_inc = 1'b0;
  logic scl, host_sda, sda_line, dev_sda, dev_oen, aud_wr, aud_rst;
  twc_pkg::twc_wr_t aud_data, last_wr;
  int n_mismatch = 0;
  int checked = 0;
  int n_wr = 0;
  int n_rst = 0;
  initial forever #2.5 clk_i = ~clk_i;
  initial forever #6.5 aud_clk = ~aud_clk;
  // pull-up: any party may pull the line low
  assign sda_line = host_sda & (dev_oen | dev_sda);
  twc_slave #(.NUM_REGS(128), .DEV_ID(ID_VAL)) dut_u (.clk_i(clk_i), .rstn_i(rstn_i),
    .aud_clk_i(aud_clk), .aud_rstn_i(aud_rstn), .interface_select_pin_i(if_sel),
    .addr_sel_i(addr_sel), .auto_inc_i(auto_inc), .scl_i(scl), .sda_i(sda_line),
    .sda_o(dev_sda), .sda_oen_o(dev_oen), .aud_wr_o(aud_wr), .aud_wr_data_o(aud_data),
    .aud_soft_rst_o(aud_rst));
  twc_host_model host_u (.clk_i(clk_i), .sda_i(sda_line), .scl_o(scl), .sda_o(host_sda));
  always @(posedge aud_clk) begin
    if (aud_wr === 1'b1) begin
      n_wr <= n_wr + 1;
      last_wr <= aud_data;
    end
    if (aud_rst === 1'b1) begin
      n_rst <= n_rst + 1;
    end
  end
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr_head(input logic [7:0] dev, input logic [7:0] idx, input logic sp);
    logic [7:0] r;
    logic a;
    host_u.start();
    if (sp) begin
      host_u.spike();
    end
    host_u.byte_x(dev, 1'b1, r, a);
    chk("addr ack", a, 1'b0);
    host_u.byte_x(idx, 1'b1, r, a);
    chk("index ack", a, 1'b0);
  endtask
  task automatic wr_word(input logic [15:0] d);
    logic [7:0] r;
    logic a;
    host_u.byte_x(d[15:8], 1'b1, r, a);
    chk("hi ack", a, 1'b0);
    host_u.byte_x(d[7:0], 1'b1, r, a);
    chk("lo ack", a, 1'b0);
  endtask
  task automatic rd_head(input logic [7:0] dev, input logic [7:0] idx);
    logic [7:0] r;
    logic a;
    wr_head(dev, idx, 1'b0);
    host_u.start();
    host_u.byte_x(dev | 8'h01, 1'b1, r, a);
    chk("read addr ack", a, 1'b0);
  endtask
  // controller acks hi; last chooses ack or nack after lo
  task automatic rd_word(input logic last, output logic [15:0] d);
    logic a;
    host_u.byte_x(8'hFF, 1'b0, d[15:8], a);
    host_u.byte_x(8'hFF, last, d[7:0], a);
  endtask
  task automatic rd1(input logic [7:0] dev, input logic [7:0] idx, output logic [15:0] d);
    rd_head(dev, idx);
    rd_word(1'b1, d);
    host_u.stop();
  endtask
  task automatic t_write_read();
    logic [15:0] d;
    int w0;
    w0 = n_wr;
    wr_head(8'h34, 8'h85, 1'b1);
    wr_word(16'h1234);
    host_u.stop();
    chk("write count", n_wr, w0 + 1);
    chk("write word", last_wr, {7'h05, 16'h1234});
    chk("released", dev_oen, 1'b1);
    chk("no soft pulse", n_rst, 0);
    rd1(8'h34, 8'h05, d);
    chk("readback", d, 16'h1234);
    $display("write/read done");
  endtask
  task automatic t_addr_sel();
    logic [7:0] r;
    logic a;
    logic [15:0] d;
    addr_sel <= 1'b1;
    host_u.qtr();
    host_u.start();
    host_u.byte_x(8'h34, 1'b1, r, a);
    chk("foreign addr", a, 1'b1);
    host_u.byte_x(8'h00, 1'b1, r, a);
    chk("ignored byte", a, 1'b1);
    host_u.stop();
    wr_head(8'h36, 8'h06, 1'b0);
    wr_word(16'hABCD);
    host_u.stop();
    rd1(8'h36, 8'h06, d);
    chk("alt addr read", d, 16'hABCD);
    addr_sel <= 1'b0;
    host_u.qtr();
    $display("address select done");
  endtask
  task automatic t_abort();
    logic [7:0] r;
    logic a;
    logic [15:0] d;
    int w0;
    w0 = n_wr;
    wr_head(8'h34, 8'h05, 1'b0);
    host_u.byte_x(8'h77, 1'b1, r, a);
    host_u.stop();
    chk("no commit", n_wr, w0);
    rd1(8'h34, 8'h05, d);
    chk("kept value", d, 16'h1234);
    $display("abort done");
  endtask
  task automatic t_auto();
    logic [15:0] d;
    int w0;
    w0 = n_wr;
    auto_inc <= 1'b1;
    wr_head(8'h34, 8'h0A, 1'b0);
    wr_word(16'h1111);
    wr_word(16'h2222);
    host_u.stop();
    chk("auto count", n_wr, w0 + 2);
    chk("auto last", last_wr, {7'h0B, 16'h2222});
    rd_head(8'h34, 8'h0A);
    rd_word(1'b0, d);
    chk("auto rd 0", d, 16'h1111);
    rd_word(1'b1, d);
    chk("auto rd 1", d, 16'h2222);
    host_u.stop();
    auto_inc <= 1'b0;
    $display("auto increment done");
  endtask
  task automatic t_soft();
    logic [15:0] d;
    int r0;
    r0 = n_rst;
    wr_head(8'h34, 8'h00, 1'b0);
    wr_word(16'hFFFF);
    host_u.stop();
    chk("soft pulse", n_rst, r0 + 1);
    rd1(8'h34, 8'h05, d);
    chk("cleared", d, 16'h0000);
    rd1(8'h34, 8'h00, d);
    chk("id read", d, ID_VAL);
    $display("soft reset done");
  endtask
  task automatic t_mode();
    logic [7:0] r;
    logic a;
    if_sel <= 1'b1;
    host_u.qtr();
    host_u.start();
    host_u.byte_x(8'h34, 1'b1, r, a);
    chk("other mode", a, 1'b1);
    host_u.stop();
    if_sel <= 1'b0;
    $display("mode select done");
  endtask
  task automatic give_verdict();
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk_i);
    rstn_i <= 1'b1;
    aud_rstn <= 1'b1;
    repeat (10) @(posedge clk_i);
    t_write_read();
    t_addr_sel();
    t_abort();
    t_auto();
    t_soft();
    t_mode();
    give_verdict();
  end
  initial begin
    repeat (100000) @(posedge clk_i);
    n_mismatch++;
    give_verdict();
  end
endmodule
`default_nettype wire
